//--- core/flash_host_defines.vh
// constants for the parallel nor flash host controller
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH
`define CMD_UNLOCK1_ADDR 12'h555
`define CMD_UNLOCK2_ADDR 12'h2aa
`define CMD_UNLOCK1_DATA 8'haa
`define CMD_UNLOCK2_DATA 8'h55
`define CMD_AUTOSEL 8'h90
`define CMD_PROGRAM 8'ha0
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_RST1 8'h90
`define CMD_BYPASS_RST2 8'h00
`define CMD_RESET 8'hf0
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define OP_READ 4'h0
`define OP_RESET 4'h1
`define OP_AUTOSEL 4'h2
`define OP_PROGRAM 4'h3
`define OP_BYPASS 4'h4
`define OP_BYPASS_PROG 4'h5
`define OP_BYPASS_RST 4'h6
`define OP_SUSPEND 4'h7
`define OP_RESUME 4'h8
`define OP_SECT_ERASE 4'h9
`define OP_POLL 4'ha
`define SECTOR_LSB 12
`define SECTOR_MSB 20
`define PROT_UNPROT 8'h00
`define PROT_PROT 8'h01
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define TIMEOUT_BIT 5
`define T_SETUP_NS 40
`define T_PULSE_NS 40
`define T_HOLD_NS 20
`define CLK_NS 20
`define T_SETUP_CYC ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_PULSE_CYC ((`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_HOLD_CYC ((`T_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- core/flash_bus_cycle.v
// one flash bus cycle: write or read with strobe timing
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_bus_cycle #(
	parameter AW = 21,
	parameter DW = 16
) (
	input wire clk,
	input wire srst,
	input wire start, // pulse: begin a cycle
	input wire is_write, // high for write cycle
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg done_r, // pulse: cycle finished
	output reg [DW-1:0] rdata_r,
	output reg [AW-1:0] addr_r,
	output reg [DW-1:0] dq_out_r,
	output reg dq_oe_n_r, // low while driving data pins
	output reg ce_n_r,
	output reg we_n_r,
	output reg oe_n_r,
	input wire [DW-1:0] dq_in
);
	localparam S_IDLE = 4'b0001;
	localparam S_SETUP = 4'b0010;
	localparam S_PULSE = 4'b0100;
	localparam S_HOLD = 4'b1000;
	// phase lengths in clocks; only the low byte reaches the counter
	localparam integer SETUP_LEN = `T_SETUP_CYC;
	localparam integer PULSE_LEN = `T_PULSE_CYC;
	localparam integer HOLD_LEN = `T_HOLD_CYC;
	reg [3:0] st_r;
	reg [7:0] cnt_r;
	reg wr_r;
	// address set up with chip select, then strobe, then release
	always @(posedge clk) begin
		done_r <= 1'b0;
		if (srst) begin
			st_r <= S_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			rdata_r <= {DW{1'b0}};
			addr_r <= {AW{1'b0}};
			dq_out_r <= {DW{1'b0}};
			dq_oe_n_r <= 1'b1;
			ce_n_r <= 1'b1;
			we_n_r <= 1'b1;
			oe_n_r <= 1'b1;
		end else begin
			case (st_r)
			S_IDLE: begin
				if (start) begin
					wr_r <= is_write;
					addr_r <= addr;
					dq_out_r <= wdata;
					dq_oe_n_r <= ~is_write;
					ce_n_r <= 1'b0;
					cnt_r <= SETUP_LEN[7:0];
					st_r <= S_SETUP;
				end
			end
			S_SETUP: begin
				if (cnt_r <= 8'h01) begin
					// chip select already low, so write strobe falls later
					// and the device latches the address here
					we_n_r <= ~wr_r;
					oe_n_r <= wr_r;
					cnt_r <= PULSE_LEN[7:0];
					st_r <= S_PULSE;
				end else
					cnt_r <= cnt_r - 8'h01;
			end
			S_PULSE: begin
				if (cnt_r <= 8'h01) begin
					// write strobe rises first; data latched here
					we_n_r <= 1'b1;
					oe_n_r <= 1'b1;
					if (!wr_r)
						rdata_r <= dq_in;
					cnt_r <= HOLD_LEN[7:0];
					st_r <= S_HOLD;
				end else
					cnt_r <= cnt_r - 8'h01;
			end
			S_HOLD: begin
				// data held past strobe; chip select last to rise
				if (cnt_r <= 8'h01) begin
					ce_n_r <= 1'b1;
					dq_oe_n_r <= 1'b1;
					done_r <= 1'b1;
					st_r <= S_IDLE;
				end else
					cnt_r <= cnt_r - 8'h01;
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule // flash_bus_cycle

//--- core/flash_command_sequencer.v
// host-side command sequencer for a parallel nor flash
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_command_sequencer #(
	parameter AW = 21,
	parameter DW = 16
) (
	input wire clk,
	input wire srst,
	input wire req, // pulse: take an operation
	input wire [3:0] op, // operation code
	input wire [AW-1:0] user_addr,
	input wire [DW-1:0] user_data,
	output reg busy_r, // high while an operation runs
	output reg done_r, // pulse: operation finished
	output reg err_r, // pulse with done: refused or failed
	output reg [DW-1:0] rd_data_r, // read or status result
	output reg protected_r, // last autoselect protection answer
	output reg bypass_r, // device believed in bypass mode
	output reg suspended_r, // device believed erase-suspended
	output reg [AW-1:0] addr_pin_r,
	output reg [DW-1:0] dq_out_r,
	output reg dq_oe_n_r,
	output reg ce_n_r,
	output reg we_n_r,
	output reg oe_n_r,
	input wire [DW-1:0] dq_in,
	input wire ready_busy_out // from device, low while busy
);
	localparam S_IDLE = 4'b0001;
	localparam S_CYC = 4'b0010;
	localparam S_WAIT = 4'b0100;
	localparam S_FIN = 4'b1000;
	reg [3:0] st_r;
	reg [3:0] op_r;
	reg [2:0] idx_r; // cycle index in sequence
	reg [AW-1:0] ua_r;
	reg [DW-1:0] ud_r;
	reg cyc_start_r;
	reg cyc_wr_r;
	reg [AW-1:0] cyc_a_r;
	reg [DW-1:0] cyc_d_r;
	reg erasing_r; // sector erase launched, not suspended
	reg [DW-1:0] prev_r; // last status for toggle compare
	wire c_done;
	wire [DW-1:0] c_rdata;
	wire [AW-1:0] c_addr;
	wire [DW-1:0] c_dq;
	wire c_oe_n;
	wire c_ce_n;
	wire c_we_n;
	wire c_oen;
	// command address: low bits only, upper bits zero
	function [AW-1:0] cmd_a;
		input [11:0] a;
		cmd_a = {{(AW-12){1'b0}}, a};
	endfunction
	// sector address keeps bits 20..12 of the user address
	function [AW-1:0] sect_a;
		input [AW-1:0] a;
		sect_a = {a[`SECTOR_MSB:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
	endfunction
	// number of bus cycles in each operation
	function [2:0] seq_len;
		input [3:0] o;
		case (o)
		`OP_READ, `OP_RESET, `OP_SUSPEND, `OP_RESUME: seq_len = 3'd1;
		`OP_BYPASS_PROG, `OP_BYPASS_RST, `OP_POLL: seq_len = 3'd2;
		`OP_BYPASS: seq_len = 3'd3;
		`OP_AUTOSEL, `OP_PROGRAM: seq_len = 3'd4;
		`OP_SECT_ERASE: seq_len = 3'd6;
		default: seq_len = 3'd1;
		endcase
	endfunction
	// legality of an operation in the current believed mode
	function legal;
		input [3:0] o;
		input byp;
		input sus;
		input ers;
		case (o)
		`OP_BYPASS_PROG, `OP_BYPASS_RST: legal = byp;
		`OP_RESUME: legal = sus;
		`OP_SUSPEND: legal = ers;
		`OP_SECT_ERASE, `OP_BYPASS: legal = ~byp & ~sus & ~ers;
		// suspend still allows read, program, autoselect
		`OP_READ, `OP_AUTOSEL, `OP_PROGRAM, `OP_RESET, `OP_POLL:
			legal = ~byp | (o == `OP_READ) | (o == `OP_POLL);
		default: legal = 1'b0;
		endcase
	endfunction
	flash_bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
		.clk(clk),
		.srst(srst),
		.start(cyc_start_r),
		.is_write(cyc_wr_r),
		.addr(cyc_a_r),
		.wdata(cyc_d_r),
		.done_r(c_done),
		.rdata_r(c_rdata),
		.addr_r(c_addr),
		.dq_out_r(c_dq),
		.dq_oe_n_r(c_oe_n),
		.ce_n_r(c_ce_n),
		.we_n_r(c_we_n),
		.oe_n_r(c_oen),
		.dq_in(dq_in)
	);
	// pins retimed so every output leaves from a flop here
	always @(posedge clk) begin
		if (srst) begin
			addr_pin_r <= {AW{1'b0}};
			dq_out_r <= {DW{1'b0}};
			dq_oe_n_r <= 1'b1;
			ce_n_r <= 1'b1;
			we_n_r <= 1'b1;
			oe_n_r <= 1'b1;
		end else begin
			addr_pin_r <= c_addr;
			dq_out_r <= c_dq;
			dq_oe_n_r <= c_oe_n;
			ce_n_r <= c_ce_n;
			we_n_r <= c_we_n;
			oe_n_r <= c_oen;
		end
	end
	// pick the bus cycle for step idx of the latched operation
	always @* begin
		cyc_wr_r = 1'b1; // every command cycle is a write
		cyc_a_r = cmd_a(`CMD_UNLOCK1_ADDR);
		cyc_d_r = {{(DW-8){1'b0}}, `CMD_UNLOCK1_DATA};
		case (op_r)
		`OP_READ: begin
			cyc_wr_r = 1'b0; // straight read, no unlock
			cyc_a_r = ua_r;
		end
		`OP_RESET: cyc_d_r = {{(DW-8){1'b0}}, `CMD_RESET};
		`OP_SUSPEND: cyc_d_r = {{(DW-8){1'b0}}, `CMD_SUSPEND};
		`OP_RESUME: cyc_d_r = {{(DW-8){1'b0}}, `CMD_RESUME};
		`OP_POLL: begin
			cyc_wr_r = 1'b0; // two status reads at program address
			cyc_a_r = ua_r;
		end
		`OP_BYPASS_PROG: begin
			cyc_d_r = (idx_r == 3'd0) ?
				{{(DW-8){1'b0}}, `CMD_PROGRAM} : ud_r;
			if (idx_r != 3'd0)
				cyc_a_r = ua_r; // program_addr
		end
		`OP_BYPASS_RST: cyc_d_r = (idx_r == 3'd0) ?
			{{(DW-8){1'b0}}, `CMD_BYPASS_RST1} :
			{{(DW-8){1'b0}}, `CMD_BYPASS_RST2};
		default: begin
			// unlock pair, then the command byte
			if (idx_r == 3'd1 || idx_r == 3'd4) begin
				cyc_a_r = cmd_a(`CMD_UNLOCK2_ADDR);
				cyc_d_r = {{(DW-8){1'b0}}, `CMD_UNLOCK2_DATA};
			end else if (idx_r == 3'd2) begin
				case (op_r)
				`OP_AUTOSEL: cyc_d_r = {{(DW-8){1'b0}}, `CMD_AUTOSEL};
				`OP_PROGRAM: cyc_d_r = {{(DW-8){1'b0}}, `CMD_PROGRAM};
				`OP_BYPASS: cyc_d_r = {{(DW-8){1'b0}}, `CMD_BYPASS};
				default: cyc_d_r = {{(DW-8){1'b0}}, `CMD_ERASE_SETUP};
				endcase
			end else if (idx_r == 3'd3) begin
				if (op_r == `OP_AUTOSEL) begin
					cyc_wr_r = 1'b0; // fourth cycle reads
					cyc_a_r = ua_r;
				end else if (op_r == `OP_PROGRAM) begin
					cyc_a_r = ua_r; // program_addr
					cyc_d_r = ud_r; // program_data
				end
			end else if (idx_r == 3'd5) begin
				cyc_a_r = sect_a(ua_r); // sector_addr
				cyc_d_r = {{(DW-8){1'b0}}, `CMD_SECTOR_ERASE};
			end
		end
		endcase
	end
	// operation sequencer
	always @(posedge clk) begin
		done_r <= 1'b0;
		err_r <= 1'b0;
		cyc_start_r <= 1'b0;
		if (srst) begin
			st_r <= S_IDLE;
			op_r <= `OP_READ;
			idx_r <= 3'd0;
			ua_r <= {AW{1'b0}};
			ud_r <= {DW{1'b0}};
			busy_r <= 1'b0;
			rd_data_r <= {DW{1'b0}};
			protected_r <= 1'b0;
			bypass_r <= 1'b0;
			suspended_r <= 1'b0;
			erasing_r <= 1'b0;
			prev_r <= {DW{1'b0}};
		end else begin
			case (st_r)
			S_IDLE: begin
				if (req) begin
					op_r <= op;
					ua_r <= user_addr;
					ud_r <= user_data;
					idx_r <= 3'd0;
					if (legal(op, bypass_r, suspended_r, erasing_r)) begin
						busy_r <= 1'b1;
						cyc_start_r <= 1'b1;
						st_r <= S_CYC;
					end else begin
						done_r <= 1'b1; // refused, nothing on the pins
						err_r <= 1'b1;
					end
				end
			end
			S_CYC: begin
				if (c_done) begin
					if (op_r == `OP_POLL && idx_r == 3'd0)
						prev_r <= c_rdata;
					if (!cyc_wr_r)
						rd_data_r <= c_rdata;
					if (idx_r + 3'd1 == seq_len(op_r)) begin
						st_r <= S_WAIT;
					end else begin
						idx_r <= idx_r + 3'd1;
						cyc_start_r <= 1'b1;
					end
				end
			end
			S_WAIT: begin
				// wait on ready/busy after a program
				if (!((op_r == `OP_PROGRAM || op_r == `OP_BYPASS_PROG) &&
					!ready_busy_out))
					st_r <= S_FIN;
			end
			S_FIN: begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
				st_r <= S_IDLE;
				case (op_r)
				`OP_AUTOSEL:
					protected_r <= (rd_data_r[7:0] == `PROT_PROT);
				`OP_BYPASS: bypass_r <= 1'b1;
				`OP_BYPASS_RST: bypass_r <= 1'b0;
				`OP_SECT_ERASE: erasing_r <= 1'b1;
				`OP_SUSPEND: begin
					erasing_r <= 1'b0;
					suspended_r <= 1'b1;
				end
				`OP_RESUME: begin
					suspended_r <= 1'b0;
					erasing_r <= 1'b1;
				end
				`OP_POLL: begin
					// toggle stops and ready/busy high once done
					if (prev_r[`TOGGLE_BIT] == rd_data_r[`TOGGLE_BIT] &&
						ready_busy_out) begin
						if (erasing_r)
							erasing_r <= 1'b0;
						// bit 7 must match the programmed value
						err_r <= ~erasing_r &
							(rd_data_r[`POLL_BIT] != ud_r[`POLL_BIT]);
					end else
						err_r <= rd_data_r[`TIMEOUT_BIT];
				end
				default: ;
				endcase
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule // flash_command_sequencer

//--- verification/flash_command_sequencer_monitor.sv
// assertion checker bound to the flash command sequencer ports
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_seq_monitor #(
	parameter AW = 21,
	parameter DW = 16
) (
	input wire clk,
	input wire srst,
	input wire req,
	input wire [3:0] op,
	input wire busy_r,
	input wire done_r,
	input wire err_r,
	input wire bypass_r,
	input wire suspended_r,
	input wire [AW-1:0] addr_pin_r,
	input wire [DW-1:0] dq_out_r,
	input wire dq_oe_n_r,
	input wire ce_n_r,
	input wire we_n_r,
	input wire oe_n_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// idle request, not in a done cycle
	wire idle = req && !busy_r && !done_r;
	a_write_in_select: assert property (
		!we_n_r |-> !ce_n_r && oe_n_r)
		else $error("write strobe outside select");
	a_write_drives_bus: assert property (
		!we_n_r |-> !dq_oe_n_r)
		else $error("write strobe without data");
	a_read_frees_bus: assert property (
		!oe_n_r |-> dq_oe_n_r && we_n_r)
		else $error("read with bus driven");
	a_addr_held: assert property (
		!we_n_r && !$past(we_n_r) |-> $stable(addr_pin_r))
		else $error("address moved in strobe");
	a_data_at_rise: assert property (
		$rose(we_n_r) |-> $stable(dq_out_r) && !ce_n_r)
		else $error("data moved at strobe rise");
	a_err_with_done: assert property (
		err_r |-> done_r)
		else $error("error without done");
	a_resume_refused: assert property (
		idle && op == `OP_RESUME && !suspended_r
		|=> done_r && err_r && ce_n_r)
		else $error("resume not refused");
	a_bprog_refused: assert property (
		idle && op == `OP_BYPASS_PROG && !bypass_r
		|=> done_r && err_r && ce_n_r)
		else $error("bypass program not refused");
	c_refused: cover property (done_r && err_r);
	c_write: cover property (!we_n_r);
	c_read: cover property (!oe_n_r);
endmodule // flash_seq_monitor
bind flash_command_sequencer flash_seq_monitor #(.AW(AW), .DW(DW)) mon_u (
	.clk, .srst, .req, .op, .busy_r, .done_r, .err_r, .bypass_r,
	.suspended_r, .addr_pin_r, .dq_out_r, .dq_oe_n_r, .ce_n_r, .we_n_r,
	.oe_n_r);

//--- verification/nor_flash_model.sv
// behavioural nor flash device facing the host sequencer
`timescale 1ns/10ps
module nor_flash_model #(
	parameter PROG_NS = 2000, // shortened program time
	parameter ERASE_NS = 4000, // shortened erase time
	parameter PROT_SECT = 9'h005 // the one protected sector
) (
	input wire [20:0] addr_pin,
	input wire [15:0] dq_out,
	input wire dq_oe_n,
	input wire ce_n,
	input wire we_n,
	input wire oe_n,
	output wire [15:0] dq_in,
	output reg ready_busy_out
);
	reg [15:0] mem [0:255]; // folded: sector bits 13..12, low six
	reg [20:0] la; // address taken on the write strobe
	reg [15:0] pd; // datum being programmed
	reg [3:0] n; // step within a command sequence
	reg [1:0] es; // sector under erase
	reg aut, byp, ers, sus, prog, tog;
	reg [15:0] last; // last driven value
	integer i;
	event go_prog, go_ers;
	wire wr = ~we_n & ~ce_n;
	wire rd = ~oe_n & ~ce_n;
	wire u1 = la[10:0] == 11'h555; // bits 20..11 ignored
	wire u2 = la[10:0] == 11'h2aa;
	wire [7:0] d = dq_out[7:0];
	// status sits in bits 7 and 6 of the low byte
	wire [15:0] rv = prog ? {8'h0, ~pd[7], tog, 6'h0} :
		(ers & ~sus) ? {8'h0, 1'b0, tog, 6'h0} :
		aut ? {15'h0, addr_pin[20:12] == PROT_SECT} :
		mem[{addr_pin[13:12], addr_pin[5:0]}];
	// a released bus shows the inverse of its last value
	assign dq_in = !dq_oe_n ? dq_out : rd ? rv : ~last;
	initial begin
		for (i = 0; i < 256; i = i + 1)
			mem[i] = {8'h5a, i[7:0]};
		{aut, byp, ers, sus, prog, tog} = 6'h0;
		n = 4'h0;
		last = 16'h0;
		ready_busy_out = 1'b1;
	end
	// toggle bit flips on every finished read
	always @(posedge oe_n)
		tog = ~tog;
	always @(negedge rd)
		last = rv;
	// address taken as the later strobe falls
	always @(posedge wr)
		la = addr_pin;
	// data taken as the first strobe rises, then decoded
	always @(negedge wr) begin
		if (d == 8'hf0 && !byp)
			{aut, n} = 5'h00;
		else if (n == 0 && d == 8'hb0 && ers && !sus)
			{sus, ready_busy_out} = 2'b11;
		else if (n == 0 && d == 8'h30 && sus)
			{sus, ready_busy_out} = 2'b00;
		else if (n == 0 && byp && d == 8'ha0)
			n = 4'h7;
		else if (n == 0 && byp && d == 8'h90)
			n = 4'h8;
		else if ((n == 0 || n == 4) && u1 && d == 8'haa)
			n = n + 4'h1; // open also while suspended
		else if ((n == 1 || n == 5) && u2 && d == 8'h55)
			n = n + 4'h1;
		else if (n == 2 && u1 && d == 8'h90)
			{aut, n} = 5'h10;
		else if (n == 2 && u1 && d == 8'ha0)
			n = 4'h3;
		else if (n == 2 && u1 && d == 8'h20 && !ers)
			{byp, n} = 5'h10;
		else if (n == 2 && u1 && d == 8'h80)
			n = 4'h4;
		else if (n == 3 || n == 7) begin
			pd = dq_out;
			n = 4'h0;
			-> go_prog;
		end else if (n == 6 && d == 8'h30) begin
			es = la[13:12];
			{ers, ready_busy_out, n} = 6'h20;
			-> go_ers;
		end else if (n == 8 && d == 8'h00)
			{byp, n} = 5'h00;
		else
			n = 4'h0; // unknown sequence dropped
	end
	// program holds the busy line low for a fixed time
	always @(go_prog) begin
		{prog, ready_busy_out} = 2'b10;
		#PROG_NS;
		mem[{la[13:12], la[5:0]}] = pd;
		{prog, ready_busy_out} = 2'b01;
	end
	// erase runs ERASE_NS, waits until not suspended, then runs ERASE_NS more
	always @(go_ers) begin
		#ERASE_NS;
		wait (!sus);
		#ERASE_NS;
		for (i = 0; i < 256; i = i + 1)
			if (i[7:6] == es)
				mem[i] = 16'hffff;
		{ers, ready_busy_out} = 2'b01;
	end
endmodule // nor_flash_model

//--- verification/flash_command_sequencer_test.sv
// bench: host sequencer against the behavioural flash
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_command_sequencer_test;
	localparam PS = 9'h005; // protected sector of the model
	reg clk, srst, req;
	reg [3:0] op;
	reg [20:0] ua;
	reg [15:0] ud;
	reg lerr; // error flag of the last operation
	wire busy, done, err, prot, byp, sus, ce_n, we_n, oe_n, doe_n, rb;
	wire [15:0] rdd, dqo, dqi;
	wire [20:0] ap;
	integer error_cnt = 0;
	integer compares = 0;
	integer cyc = 0;
	integer k;
	flash_command_sequencer dut_u (.clk(clk), .srst(srst), .req(req),
		.op(op), .user_addr(ua), .user_data(ud), .busy_r(busy),
		.done_r(done), .err_r(err), .rd_data_r(rdd), .protected_r(prot),
		.bypass_r(byp), .suspended_r(sus), .addr_pin_r(ap),
		.dq_out_r(dqo), .dq_oe_n_r(doe_n), .ce_n_r(ce_n),
		.we_n_r(we_n), .oe_n_r(oe_n), .dq_in(dqi), .ready_busy_out(rb));
	nor_flash_model #(.PROT_SECT(PS)) dev_u (.addr_pin(ap), .dq_out(dqo),
		.dq_oe_n(doe_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.dq_in(dqi), .ready_busy_out(rb));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			summarize;
		end
	end
	task summarize;
		begin
			$display("compares %0d errors %0d", compares, error_cnt);
			if (error_cnt == 0 && compares > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk16(input [15:0] g, input [15:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t word %h want %h", $time, g, e);
			end
		end
	endtask
	task chk1(input g, input e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t flag %b want %b", $time, g, e);
			end
		end
	endtask
	// one operation: request, wait for done, keep its error flag
	task run(input [3:0] o, input [20:0] a, input [15:0] d);
		begin
			op <= o;
			ua <= a;
			ud <= d;
			req <= 1'b1;
			@(posedge clk);
			req <= 1'b0;
			k = 0;
			while (done !== 1'b1 && k < 3000) begin
				@(negedge clk);
				k = k + 1;
			end
			if (k == 3000) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t operation never finished", $time);
			end
			lerr = err;
			@(posedge clk);
		end
	endtask
	task t_prog;
		begin
			run(4'hb, 21'h0, 16'h0);
			chk1(lerr, 1'b1);
			run(`OP_READ, 21'h000005, 16'h0);
			chk16(rdd, 16'h5a05);
			run(`OP_PROGRAM, 21'h000033, 16'h1234);
			chk1(rb, 1'b1);
			chk1(busy, 1'b0);
			run(`OP_POLL, 21'h000033, 16'h1234);
			chk1(lerr, 1'b0);
			run(`OP_READ, 21'h000033, 16'h0);
			chk16(rdd, 16'h1234);
		end
	endtask
	task t_auto;
		begin
			run(`OP_AUTOSEL, {PS, 12'h002}, 16'h0);
			chk1(prot, 1'b1);
			run(`OP_RESET, 21'h0, 16'h0);
			run(`OP_AUTOSEL, 21'h001002, 16'h0);
			chk1(prot, 1'b0);
			run(`OP_RESET, 21'h0, 16'h0);
			run(`OP_READ, 21'h000006, 16'h0);
			chk16(rdd, 16'h5a06);
		end
	endtask
	task t_bypass;
		begin
			run(`OP_BYPASS_PROG, 21'h000041, 16'hbeef);
			chk1(lerr, 1'b1);
			run(`OP_BYPASS, 21'h0, 16'h0);
			chk1(byp, 1'b1);
			run(`OP_BYPASS_PROG, 21'h000041, 16'hbeef);
			chk1(lerr, 1'b0);
			run(`OP_AUTOSEL, 21'h000002, 16'h0);
			chk1(lerr, 1'b1);
			run(`OP_BYPASS_RST, 21'h0, 16'h0);
			chk1(byp, 1'b0);
			run(`OP_READ, 21'h000041, 16'h0);
			chk16(rdd, 16'hbeef);
		end
	endtask
	task t_erase;
		begin
			run(`OP_RESUME, 21'h0, 16'h0);
			chk1(lerr, 1'b1);
			run(`OP_SECT_ERASE, 21'h003000, 16'h0);
			chk1(rb, 1'b0);
			// status reads while the erase runs: bit 7 low, toggling
			run(`OP_POLL, 21'h003005, 16'hffff);
			chk1(rdd[7], 1'b0);
			chk1(lerr, 1'b0);
			run(`OP_SUSPEND, 21'h0, 16'h0);
			chk1(sus, 1'b1);
			run(`OP_PROGRAM, 21'h000007, 16'h0f0f);
			run(`OP_READ, 21'h000007, 16'h0);
			chk16(rdd, 16'h0f0f);
			run(`OP_RESUME, 21'h0, 16'h0);
			chk1(sus, 1'b0);
			k = 0;
			while (rb !== 1'b1 && k < 1000) begin
				@(negedge clk);
				k = k + 1;
			end
			if (k == 1000) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t erase never finished", $time);
			end
			@(posedge clk);
			run(`OP_READ, 21'h003005, 16'h0);
			chk16(rdd, 16'hffff);
			run(`OP_READ, 21'h002005, 16'h0);
			chk16(rdd, 16'h5a85);
		end
	endtask
	initial begin
		srst = 1'b1;
		req = 1'b0;
		op = 4'h0;
		ua = 21'h0;
		ud = 16'h0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk1(ce_n & we_n & oe_n, 1'b1); // idle strobes after reset
		t_prog;
		t_auto;
		t_bypass;
		t_erase;
		summarize;
	end
endmodule // flash_command_sequencer_test
